/* rcs_pkg.sv */
package rcs_pkg;
	// clock rate of the sequencer (oscillator clock)
	localparam int unsigned CLK_MHZ          = 50;
	localparam int unsigned CLK_PERIOD_NS    = 20;
	// times as specified, and the counter width
	localparam int unsigned DEV_RST_US       = 600;
	localparam int unsigned OSC_START_US     = 3;
	localparam int unsigned DEV_RST_CYC      = DEV_RST_US * 1000 / CLK_PERIOD_NS;
	localparam int unsigned OSC_START_CYC    = (OSC_START_US * 1000 + CLK_PERIOD_NS - 1)
	                                           / CLK_PERIOD_NS;
	localparam int unsigned WD_RST_CYC       = 512;
	localparam int unsigned EX_DELAY_CYC     = 32;
	localparam int unsigned WARM_MIN_CYC     = 32;
	localparam int unsigned BOOT_HOLD_CYC    = 1000;
	localparam int unsigned LOCK_MIN_10MHZ   = 10000;
	localparam int unsigned CNT_W            = 16;
	// register map (word addresses)
	localparam logic [3:0]  ADDR_CORE_DIV    = 4'h0;
	localparam logic [3:0]  ADDR_CLK_OUT     = 4'h1;
	localparam logic [3:0]  ADDR_PLL_MULT    = 4'h2;
	localparam logic [3:0]  ADDR_LOCK_PRD    = 4'h3;
	localparam logic [3:0]  ADDR_STATUS      = 4'h4;
	localparam logic [3:0]  ADDR_SW_RESET    = 4'h5;
	// field layouts and reset values
	localparam logic [1:0]  CORE_DIV_RST     = 2'h0; // /4
	localparam logic [1:0]  CORE_DIV_BOOT    = 2'h2; // /1
	localparam logic [1:0]  CLKOUT_DIV_RST   = 2'h0; // /4
	localparam int unsigned CLKOUT_EN_BIT    = 2;
	localparam logic [4:0]  PLL_MULT_RST     = 5'h00;
	localparam logic [15:0] LOCK_PRD_RST     = 16'hFFFF;
	// divide ratios and core clock source codes
	localparam logic [1:0]  DIV_BY4          = 2'h0;
	localparam logic [1:0]  DIV_BY2          = 2'h1;
	localparam logic [1:0]  DIV_BY1          = 2'h2;
	localparam logic [1:0]  CORE_SRC_OSC     = 2'h0;
	localparam logic [1:0]  CORE_SRC_HALF    = 2'h1;
	localparam logic [1:0]  CORE_SRC_PLL     = 2'h2;
endpackage

/* rcs_sync.sv */
`timescale 1ns/1ps
module rcs_sync (
	input  wire logic clk,   // sampling clock
	input  wire logic reset, // async reset
	input  wire logic d,     // asynchronous level
	output logic      q      // synchronised level
);
	typedef struct packed {
		logic s1;
		logic s2;
	} rcs_sync_st_t;
	rcs_sync_st_t st_q, st_d;

	always_comb begin
		st_d    = st_q;
		st_d.s1 = d;
		st_d.s2 = st_q.s1;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign q = st_q.s2;
endmodule

/* rcs_clkdiv.sv */
`timescale 1ns/1ps
module rcs_clkdiv (
	input  wire logic       clk,    // oscillator clock
	input  wire logic       reset,  // async reset
	input  wire logic [1:0] ratio,  // 0 /4, 1 /2, 2 /1
	input  wire logic       tick,   // input edge enable
	output logic            pulse   // one pulse per divided period
);
	typedef struct packed {
		logic [1:0] cnt;
		logic       pulse;
	} rcs_div_st_t;
	rcs_div_st_t st_q, st_d;

	function automatic logic [1:0] last_count(input logic [1:0] r);
		unique case (r)
			rcs_pkg::DIV_BY4: last_count = 2'h3;
			rcs_pkg::DIV_BY2: last_count = 2'h1;
			default:          last_count = 2'h0;
		endcase
	endfunction

	always_comb begin
		st_d       = st_q;
		st_d.pulse = 1'b0;
		if (tick) begin
			if (st_q.cnt >= last_count(ratio)) begin
				st_d.cnt   = 2'h0;
				st_d.pulse = 1'b1;
			end else begin
				st_d.cnt = st_q.cnt + 2'h1;
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign pulse = st_q.pulse;
endmodule

/* rcs_sequencer.sv */
`timescale 1ns/1ps
// Summary of operation
// [RQ1] after power-up the core clock runs at a quarter of the oscillator clock.
// [RQ2] the clock-out divider resets to zero (divide by four), so clock out is osc/16.
// [RQ3] the clock monitor pin shows nothing until software enables it.
// [RQ4] boot sets the core divide select to /1, making clock out osc/4.
// [RQ5] after any reset the boot-mode pins are sampled and reported for the branch.
// [RQ6] the reset pin may be left undriven since power-on reset acts internally.
// [RQ7] boot-mode pins must stay stable 1000 core cycles after reset release.
// [RQ8] an external warm reset holds the reset pin low at least 32 oscillator cycles.
// [RQ9] a device-driven reset pulls the reset pin low for 600 us.
// [RQ10] a watchdog reset produces a 512 oscillator-cycle reset pulse.
// [RQ11] bus activity becomes valid 32 oscillator cycles after the reset pin rises.
// [RQ12] sequencing waits 3 us for the oscillator to start before using it.
// [RQ13] a write to the pll multiplier register starts lock-up at osc/2 core clock.
// [RQ14] after lock the core clock takes the newly programmed multiplier.
// [RQ15] software programs the lock period in oscillator cycles, 10000 at 10 MHz.
// [RQ16] internal reset holds while the reset pin is low, released synchronously.
module rcs_sequencer (
	input  wire logic        clk,          // oscillator clock, 50 MHz
	input  wire logic        reset,        // power-on reset, active high
	input  wire logic        reset_pin_i,  // reset pin level in
	output logic             reset_pin_o,  // reset pin drive value (low)
	output logic             reset_pin_oe, // reset pin drive enable
	input  wire logic        wd_reset,     // watchdog reset request pulse
	input  wire logic [3:0]  boot_pins,    // boot-mode straps
	input  wire logic [3:0]  addr,         // register address
	input  wire logic [15:0] wdata,        // write data
	input  wire logic        wr,           // write strobe
	input  wire logic        rd,           // read strobe
	output logic [15:0]      rdata,        // read data, cycle after rd
	output logic             core_reset,   // internal reset to the core
	output logic             bus_valid,    // address/data activity allowed
	output logic [3:0]       boot_mode,    // sampled boot straps
	output logic             boot_valid,   // boot_mode captured
	output logic             core_tick,    // core clock enable pulse
	output logic [1:0]       core_source,  // 0 osc/div, 1 lock osc/2, 2 pll
	output logic [4:0]       core_mult,    // active pll multiplier
	output logic             clock_monitor_output // divided clock to the pin
);
	typedef enum {
		ST_OSC_WAIT,
		ST_IN_RESET,
		ST_EX_DELAY,
		ST_RUN
	} rcs_state_t;

	typedef enum {
		RS_IDLE,
		RS_DEVICE,
		RS_WATCHDOG
	} rcs_drive_t;

	typedef struct packed {
		rcs_state_t  state;
		rcs_drive_t  drive;
		logic [15:0] cnt;
		logic [15:0] drv_cnt;
		logic [1:0]  core_divide_select;
		logic [1:0]  clock_out_divider;
		logic        clock_out_enable;
		logic [4:0]  pll_multiplier;
		logic [4:0]  pll_active;
		logic [15:0] lock_period_count;
		logic [15:0] lock_cnt;
		logic        locking;
		logic [3:0]  boot_mode;
		logic        boot_valid;
		logic [15:0] rdata;
		logic        mon;
	} rcs_st_t;

	rcs_st_t    st_q, st_d;
	logic       pin_low;
	logic       pin_sync;
	logic [3:0] boot_sync;
	logic       core_pulse;
	logic       out_pulse;
	logic [1:0] core_ratio;

	// double flop before anything looks at the pin and straps
	rcs_sync u_pin_sync (
		.clk   (clk),
		.reset (reset),
		.d     (reset_pin_i),
		.q     (pin_sync)
	);
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_boot
			rcs_sync u_boot_sync (
				.clk   (clk),
				.reset (reset),
				.d     (boot_pins[gi]),
				.q     (boot_sync[gi])
			);
		end
	endgenerate

	assign pin_low = ~pin_sync;

	// lock-up forces osc/2; otherwise the programmed ratio
	assign core_ratio = st_q.locking ? rcs_pkg::DIV_BY2 : st_q.core_divide_select; // RQ13

	// monitor pin toggles twice per output period, so the divider counts half periods;
	// a /1 output setting can only show core/2 on a single clock
	function automatic logic [1:0] half_ratio(input logic [1:0] r);
		unique case (r)
			rcs_pkg::DIV_BY4: half_ratio = rcs_pkg::DIV_BY2;
			default:          half_ratio = rcs_pkg::DIV_BY1;
		endcase
	endfunction

	rcs_clkdiv u_core_div (
		.clk   (clk),
		.reset (reset),
		.ratio (core_ratio),
		.tick  (1'b1),
		.pulse (core_pulse)
	);

	rcs_clkdiv u_out_div (
		.clk   (clk),
		.reset (reset),
		.ratio (half_ratio(st_q.clock_out_divider)), // RQ2
		.tick  (core_pulse),
		.pulse (out_pulse)
	);

	always_comb begin
		st_d       = st_q;
		st_d.rdata = 16'h0000;
		if (out_pulse) begin
			st_d.mon = ~st_q.mon;
		end
		unique case (st_q.state)
			ST_OSC_WAIT: begin
				if (st_q.cnt >= 16'(rcs_pkg::OSC_START_CYC - 1)) begin // RQ12
					st_d.state = ST_IN_RESET;
					st_d.cnt   = 16'h0000;
				end else begin
					st_d.cnt = st_q.cnt + 16'h0001;
				end
			end
			ST_IN_RESET: begin
				if (!pin_low && st_q.drive == RS_IDLE) begin // RQ16
					st_d.state = ST_EX_DELAY;
					st_d.cnt   = 16'h0000;
				end
			end
			ST_EX_DELAY: begin
				if (pin_low) begin
					st_d.state = ST_IN_RESET;
				end else if (st_q.cnt >= 16'(rcs_pkg::EX_DELAY_CYC - 1)) begin // RQ11
					st_d.state      = ST_RUN;
					st_d.boot_mode  = boot_sync; // RQ5
					st_d.boot_valid = 1'b1;
					// boot code selects /1 core divide
					st_d.core_divide_select = rcs_pkg::CORE_DIV_BOOT; // RQ4
				end else begin
					st_d.cnt = st_q.cnt + 16'h0001;
				end
			end
			ST_RUN: begin
				if (pin_low) begin
					st_d.state = ST_IN_RESET;
				end
			end
			default: st_d.state = ST_IN_RESET;
		endcase

		// reset pin drive timers
		// watchdog honoured only in run, a pulse in flight is not restarted by it
		unique case (st_q.drive)
			RS_IDLE: begin
				if (wd_reset && st_q.state == ST_RUN) begin
					st_d.drive   = RS_WATCHDOG;
					st_d.drv_cnt = 16'h0000;
				end
			end
			RS_DEVICE: begin
				if (st_q.drv_cnt >= 16'(rcs_pkg::DEV_RST_CYC - 1)) begin // RQ9
					st_d.drive = RS_IDLE;
				end else begin
					st_d.drv_cnt = st_q.drv_cnt + 16'h0001;
				end
			end
			RS_WATCHDOG: begin
				if (st_q.drv_cnt >= 16'(rcs_pkg::WD_RST_CYC - 1)) begin // RQ10
					st_d.drive = RS_IDLE;
				end else begin
					st_d.drv_cnt = st_q.drv_cnt + 16'h0001;
				end
			end
			default: st_d.drive = RS_IDLE;
		endcase

		// pll lock-up
		if (st_q.locking) begin
			if (st_q.lock_cnt >= st_q.lock_period_count) begin
				st_d.locking    = 1'b0;
				st_d.pll_active = st_q.pll_multiplier; // RQ14
			end else begin
				st_d.lock_cnt = st_q.lock_cnt + 16'h0001;
			end
		end

		if (st_q.state == ST_RUN && rd) begin
			unique case (addr)
				rcs_pkg::ADDR_CORE_DIV: st_d.rdata = {14'h0000, st_q.core_divide_select};
				rcs_pkg::ADDR_CLK_OUT:  st_d.rdata = {13'h0000, st_q.clock_out_enable,
				                                      st_q.clock_out_divider};
				rcs_pkg::ADDR_PLL_MULT: st_d.rdata = {11'h000, st_q.pll_multiplier};
				rcs_pkg::ADDR_LOCK_PRD: st_d.rdata = st_q.lock_period_count;
				rcs_pkg::ADDR_STATUS:   st_d.rdata = {10'h000, st_q.locking,
				                                      st_q.boot_valid, st_q.boot_mode};
				default:                st_d.rdata = 16'h0000;
			endcase
		end
		if (st_q.state == ST_RUN && wr) begin
			unique case (addr)
				rcs_pkg::ADDR_CORE_DIV: st_d.core_divide_select = wdata[1:0];
				rcs_pkg::ADDR_CLK_OUT: begin
					st_d.clock_out_divider = wdata[1:0];
					st_d.clock_out_enable  = wdata[rcs_pkg::CLKOUT_EN_BIT];
				end
				rcs_pkg::ADDR_PLL_MULT: begin
					st_d.pll_multiplier = wdata[4:0];
					st_d.locking        = 1'b1; // RQ13
					st_d.lock_cnt       = 16'h0000;
				end
				rcs_pkg::ADDR_LOCK_PRD: st_d.lock_period_count = wdata;
				rcs_pkg::ADDR_SW_RESET: begin
					if (wdata[0]) begin
						st_d.drive   = RS_DEVICE;
						st_d.drv_cnt = 16'h0000;
					end
				end
				default: ;
			endcase
		end

		// any reset returns clock setup to power-up values; the lock period keeps its value except on power-on reset
		if (st_q.state != ST_RUN && st_d.state == ST_IN_RESET) begin
			st_d.core_divide_select = rcs_pkg::CORE_DIV_RST;    // RQ1
			st_d.clock_out_divider  = rcs_pkg::CLKOUT_DIV_RST;  // RQ2
			st_d.clock_out_enable   = 1'b0;                     // RQ3
			st_d.pll_multiplier     = rcs_pkg::PLL_MULT_RST;
			st_d.pll_active         = rcs_pkg::PLL_MULT_RST;
			st_d.locking            = 1'b0;
			st_d.boot_valid         = 1'b0;
		end
		if (st_q.state == ST_RUN && pin_low) begin
			st_d.core_divide_select = rcs_pkg::CORE_DIV_RST;    // RQ1
			st_d.clock_out_divider  = rcs_pkg::CLKOUT_DIV_RST;  // RQ2
			st_d.clock_out_enable   = 1'b0;                     // RQ3
			st_d.pll_multiplier     = rcs_pkg::PLL_MULT_RST;
			st_d.pll_active         = rcs_pkg::PLL_MULT_RST;
			st_d.locking            = 1'b0;
			st_d.boot_valid         = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_q                    <= '0;
			st_q.state              <= ST_OSC_WAIT;
			st_q.drive              <= RS_IDLE;
			st_q.core_divide_select <= rcs_pkg::CORE_DIV_RST;
			st_q.clock_out_divider  <= rcs_pkg::CLKOUT_DIV_RST;
			st_q.pll_multiplier     <= rcs_pkg::PLL_MULT_RST;
			st_q.pll_active         <= rcs_pkg::PLL_MULT_RST;
			st_q.lock_period_count  <= rcs_pkg::LOCK_PRD_RST;
		end else begin
			st_q <= st_d;
		end
	end

	assign reset_pin_o          = 1'b0;
	assign reset_pin_oe         = (st_q.drive != RS_IDLE);
	assign core_reset           = (st_q.state != ST_RUN) && (st_q.state != ST_EX_DELAY); // RQ16
	assign bus_valid            = (st_q.state == ST_RUN);
	assign boot_mode            = st_q.boot_mode;
	assign boot_valid           = st_q.boot_valid;
	assign core_tick            = core_pulse;
	assign core_source          = st_q.locking ? rcs_pkg::CORE_SRC_HALF :
	                              (st_q.pll_active != 5'h00 ? rcs_pkg::CORE_SRC_PLL :
	                               rcs_pkg::CORE_SRC_OSC);
	assign core_mult            = st_q.pll_active;
	assign rdata                = st_q.rdata;
	assign clock_monitor_output = st_q.clock_out_enable & st_q.mon; // RQ3

	// sequencing, reset pin pulse and clock setup checks
	wd_pulse_len_a: assert property (@(posedge clk) disable iff (reset) // RQ10
		$rose(st_q.drive == RS_WATCHDOG) |-> (st_q.drive == RS_WATCHDOG) [*8])
		else $error("watchdog pulse ended early");
	lock_half_a: assert property (@(posedge clk) disable iff (reset) // RQ13
		(wr && addr == rcs_pkg::ADDR_PLL_MULT && st_q.state == ST_RUN && !pin_low)
		|=> st_q.locking)
		else $error("pll write did not start lock-up");
	mon_hidden_a: assert property (@(posedge clk) disable iff (reset) // RQ3
		!st_q.clock_out_enable |-> !clock_monitor_output)
		else $error("clock monitor visible while disabled");
	ex_delay_a: assert property (@(posedge clk) disable iff (reset) // RQ11
		$rose(st_q.state == ST_EX_DELAY) |-> !bus_valid [*8])
		else $error("bus valid too soon after reset pin release");
	rst_hold_a: assert property (@(posedge clk) disable iff (reset) // RQ16
		(pin_low && st_q.state != ST_EX_DELAY) |=> !bus_valid)
		else $error("bus valid while reset pin low");

	boot_capture_a: assert property (@(posedge clk) disable iff (reset) // RQ5
		$rose(bus_valid) |-> boot_valid && boot_mode == $past(boot_sync))
		else $error("boot straps not captured on leaving reset");

	boot_div_a: assert property (@(posedge clk) disable iff (reset) // RQ4
		$rose(bus_valid) |-> st_q.core_divide_select == rcs_pkg::CORE_DIV_BOOT)
		else $error("core divide not set to one at boot");

	pwrup_div_a: assert property (@(posedge clk) disable iff (reset) // RQ1 RQ2
		core_reset |-> st_q.core_divide_select == rcs_pkg::CORE_DIV_RST
			&& st_q.clock_out_divider == rcs_pkg::CLKOUT_DIV_RST && !st_q.clock_out_enable)
		else $error("clock setup not at power-up values in reset");

	drive_len_a: assert property (@(posedge clk) disable iff (reset) // RQ9 RQ10
		$fell(reset_pin_oe) |-> $past(st_q.drv_cnt) == ($past(st_q.drive == RS_WATCHDOG) ?
			16'(rcs_pkg::WD_RST_CYC - 1) : 16'(rcs_pkg::DEV_RST_CYC - 1)))
		else $error("reset pin pulse of wrong length");

	ex_len_a: assert property (@(posedge clk) disable iff (reset) // RQ11
		$rose(bus_valid) |-> $past(st_q.cnt) == 16'(rcs_pkg::EX_DELAY_CYC - 1))
		else $error("bus valid not after the full release delay");

	osc_wait_a: assert property (@(posedge clk) disable iff (reset) // RQ12
		$fell(st_q.state == ST_OSC_WAIT)
			|-> $past(st_q.cnt) == 16'(rcs_pkg::OSC_START_CYC - 1))
		else $error("oscillator start wait cut short");

	lock_switch_a: assert property (@(posedge clk) disable iff (reset) // RQ14
		$fell(st_q.locking) && bus_valid |-> core_mult == $past(st_q.pll_multiplier))
		else $error("core clock did not take the new multiplier after lock");
endmodule

/* rcs_ext_model.sv */
`timescale 1ns/1ps
module rcs_ext_model (
	input  wire logic       clk,       // oscillator clock
	input  wire logic       pin_level, // resolved reset pin level
	input  wire logic       core_tick, // core clock enable pulse
	input  wire logic       warm_go,   // start a warm reset pulse
	input  wire logic [3:0] boot_req,  // strap value wanted next
	output logic            pull_low,  // drives the reset pin low
	output logic [3:0]      boot_pins  // boot-mode straps
);
	int unsigned low_cnt;
	int unsigned high_cnt;
	initial begin
		pull_low  = 1'b0;
		boot_pins = boot_req;
		low_cnt   = 0;
		high_cnt  = 0;
	end
	always @(posedge clk) begin
		if (warm_go) begin
			low_cnt <= rcs_pkg::WARM_MIN_CYC;
		end else if (low_cnt != 0) begin
			low_cnt <= low_cnt - 1;
		end
		pull_low <= warm_go || low_cnt > 1;
		high_cnt <= pin_level ? high_cnt + core_tick : 0;
		// straps move only while reset is held or long after release
		if (!pin_level || high_cnt >= rcs_pkg::BOOT_HOLD_CYC) begin
			boot_pins <= boot_req;
		end
	end
endmodule

/* tb.sv */
`timescale 1ns/1ps
module tb;
	logic clk = 1'b0, reset = 1'b1, wd_reset = 1'b0, wr = 1'b0, rd = 1'b0, warm_go = 1'b0;
	logic [3:0] addr = 4'h0, boot_req = 4'h5, boot_pins;
	logic [15:0] wdata = 16'h0000, rdata, rv;
	logic reset_pin_o, reset_pin_oe, core_reset, bus_valid, boot_valid, core_tick;
	logic clock_monitor_output, pull_low, pin_level;
	logic [3:0] boot_mode;
	logic [1:0] core_source;
	logic [4:0] core_mult;
	int fails = 0, n_checks = 0, n;
	assign pin_level = !(pull_low || (reset_pin_oe && !reset_pin_o));
	rcs_sequencer i_dut (.clk(clk), .reset(reset), .reset_pin_i(pin_level),
		.reset_pin_o(reset_pin_o), .reset_pin_oe(reset_pin_oe), .wd_reset(wd_reset),
		.boot_pins(boot_pins), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.core_reset(core_reset), .bus_valid(bus_valid), .boot_mode(boot_mode),
		.boot_valid(boot_valid), .core_tick(core_tick), .core_source(core_source),
		.core_mult(core_mult), .clock_monitor_output(clock_monitor_output));
	rcs_ext_model i_ext (.clk(clk), .pin_level(pin_level), .warm_go(warm_go),
		.core_tick(core_tick), .boot_req(boot_req), .pull_low(pull_low),
		.boot_pins(boot_pins));
	initial begin
		forever #10 clk = ~clk;
	end
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s expected %0h seen %0h", name, exp, seen);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic cyc();
		@(posedge clk);
		#1;
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	task automatic count_ticks(input int cycles, output int c);
		c = 0;
		repeat (cycles) begin
			cyc();
			c += (core_tick === 1'b1);
		end
	endtask
	task automatic wait_run(output int c);
		c = 0;
		while (bus_valid !== 1'b1 && c < 2000) begin
			cyc();
			c++;
		end
		chk("run_reached", bus_valid, 1'b1);
	endtask
	task automatic t_startup();
		int t;
		count_ticks(40, n);
		chk("boot_core_ticks", n, 10);
		chk("core_reset_start", core_reset, 1'b1);
		wait_run(t);
		t += 40;
		chk("start_delay", t >= rcs_pkg::OSC_START_CYC + rcs_pkg::EX_DELAY_CYC, 1'b1);
		chk("start_bound", t <= rcs_pkg::OSC_START_CYC + rcs_pkg::EX_DELAY_CYC + 4, 1'b1);
		chk("boot_mode", boot_mode, 4'h5);
		chk("boot_valid", boot_valid, 1'b1);
	endtask
	task automatic t_regs();
		rd_reg(rcs_pkg::ADDR_CLK_OUT, rv);
		chk("clk_out_rst", rv, 16'h0000);
		rd_reg(rcs_pkg::ADDR_CORE_DIV, rv);
		chk("core_div_boot", rv, {14'h0000, rcs_pkg::CORE_DIV_BOOT});
		rd_reg(rcs_pkg::ADDR_LOCK_PRD, rv);
		chk("lock_prd_rst", rv, rcs_pkg::LOCK_PRD_RST);
		rd_reg(4'hF, rv);
		chk("unmapped", rv, 16'h0000);
		count_ticks(16, n);
		chk("core_div1_ticks", n, 16);
		n = 0;
		repeat (64) begin
			cyc();
			n += (clock_monitor_output !== 1'b0);
		end
		chk("monitor_hidden", n, 0);
	endtask
	task automatic t_clkout();
		logic        last;
		logic [15:0] cfg [2] = '{16'h0004, 16'h0005};
		int          want [2] = '{32, 64};
		foreach (cfg[j]) begin
			wr_reg(rcs_pkg::ADDR_CLK_OUT, cfg[j]);
			repeat (8) cyc();
			last = clock_monitor_output;
			n = 0;
			repeat (64) begin
				cyc();
				n += (clock_monitor_output !== last);
				last = clock_monitor_output;
			end
			chk("monitor_toggles", n, want[j]);
		end
	endtask
	task automatic t_pll();
		logic [4:0] mv [2] = '{5'h04, 5'h08};
		int t;
		wr_reg(rcs_pkg::ADDR_LOCK_PRD, 16'h0014);
		foreach (mv[i]) begin
			wr_reg(rcs_pkg::ADDR_PLL_MULT, {11'h000, mv[i]});
			#1;
			chk("lock_src", core_source, rcs_pkg::CORE_SRC_HALF);
			count_ticks(10, n);
			chk("lock_ticks", n, 5);
			t = 10;
			while (core_source !== rcs_pkg::CORE_SRC_PLL && t < 60) begin
				cyc();
				t++;
			end
			chk("lock_len", t >= 20 && t <= 23, 1'b1);
			chk("pll_mult", core_mult, mv[i]);
		end
	endtask
	task automatic pulse_len(output int c);
		int w;
		w = 0;
		c = 0;
		#1;
		while (reset_pin_oe !== 1'b1 && w < 20) begin
			cyc();
			w++;
		end
		while (reset_pin_oe === 1'b1 && c < 40000) begin
			cyc();
			c++;
		end
	endtask
	task automatic t_warm();
		@(posedge clk);
		boot_req <= 4'hA;
		warm_go  <= 1'b1;
		@(posedge clk);
		warm_go <= 1'b0;
		repeat (10) cyc();
		chk("warm_core_reset", core_reset, 1'b1);
		chk("warm_bus", bus_valid, 1'b0);
		while (pin_level !== 1'b1) cyc();
		wait_run(n);
		chk("warm_ex_delay", n >= rcs_pkg::EX_DELAY_CYC && n <= 36, 1'b1);
		rd_reg(rcs_pkg::ADDR_STATUS, rv);
		chk("warm_status", rv, 16'h001A);
	endtask
	task automatic t_wd();
		@(posedge clk);
		wd_reset <= 1'b1;
		@(posedge clk);
		wd_reset <= 1'b0;
		pulse_len(n);
		chk("wd_pulse", n, rcs_pkg::WD_RST_CYC);
		wait_run(n);
		wr_reg(rcs_pkg::ADDR_SW_RESET, 16'h0001);
		chk("pin_drive_low", reset_pin_o, 1'b0);
		pulse_len(n);
		chk("dev_pulse", n, rcs_pkg::DEV_RST_CYC);
		wait_run(n);
		rd_reg(rcs_pkg::ADDR_CLK_OUT, rv);
		chk("clk_out_after_rst", rv, 16'h0000);
	endtask
	initial begin
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		t_startup();
		t_regs();
		t_clkout();
		t_pll();
		t_warm();
		t_wd();
		end_sim();
	end
	initial begin
		#1500000;
		fails++;
		end_sim();
	end
endmodule
